// ==== hdl/fppio_top.sv ====
`timescale 1ns/100ps
// Contract
// - 32 pins, four ports, each direction programmable
// - direction bit governs matching pin
// - reset leaves data latches unchanged
// - port a pins are converter inputs
// - led drive per port a pin
// - open-drain pins drive low only
// - selected converter channel overrides port logic
// - read latch if output, pin if input
// - enabled peripheral overrides its pins except the selected converter pin
module fppio_top
    import fppio_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire fppio_apb_req_type apb_req,
    output fppio_apb_rsp_type apb_rsp,
    input wire logic [31:0] pin_in,
    output fppio_pad_type pad,
    input wire logic [4:0] converter_channel_select,
    output logic [7:0] converter_input_select,
    input wire logic [31:0] periph_own,
    input wire logic [31:0] periph_out,
    input wire logic [31:0] periph_oe
);
    logic [7:0] latch_q [fppio_ports];
    logic [7:0] latch_d [fppio_ports];
    logic [7:0] dir_q [fppio_ports];
    logic [7:0] dir_d [fppio_ports];
    logic [7:0] led_q;
    logic [7:0] led_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic err_q;
    logic err_d;
    fppio_state_type state_q;
    fppio_state_type state_d;
    logic [31:0] own_all;
    logic [31:0] read_bits;
    logic [31:0] pin_out_w;
    logic [31:0] oe_n_w;
    logic [11:0] idx;
    logic setup;
    logic wr_go;
    logic hit_latch;
    logic hit_dir;
    logic hit_led;

    assign idx = {2'b00, apb_req.paddr[11:2]};
    assign setup = apb_req.psel && !apb_req.penable;
    // writes land at the access edge that samples pready, never at setup
    assign wr_go = apb_req.psel && apb_req.penable && apb_req.pwrite
        && (state_q == fppio_access);

    always_comb
    begin
        converter_input_select = 8'h00;
        own_all = periph_own;
        if (converter_channel_select <= fppio_channel_limit)
        begin
            converter_input_select[converter_channel_select[2:0]] = 1'b1;
            own_all[7:0] = periph_own[7:0] | converter_input_select;
        end
    end

    genvar g;
    generate
        for (g = 0; g < fppio_pins; g++)
        begin : g_pin
            fppio_pin_cell u_cell (
                .latch_bit(latch_q[g / 8][g % 8]),
                .dir_bit(dir_q[g / 8][g % 8]),
                .open_drain(fppio_open_drain_mask[g]),
                .periph_own(own_all[g]),
                .periph_out(periph_out[g]),
                // converter owning a pin leaves it undriven
                .periph_oe(periph_oe[g] && !(g < 8 && converter_input_select[g % 8])),
                .pin_in(pin_in[g]),
                .pin_out(pin_out_w[g]),
                .pin_oe_n(oe_n_w[g]),
                .read_bit(read_bits[g])
            );
        end
    endgenerate

    always_comb
    begin
        pad.pin_out = pin_out_w;
        pad.pin_oe_n = oe_n_w;
        pad.led_drive = led_q & dir_q[0];
        apb_rsp.prdata = rdata_q;
        apb_rsp.pready = (state_q == fppio_access);
        apb_rsp.pslverr = err_q;
    end

    // address decode, shared by reads and writes
    always_comb
    begin
        hit_latch = 1'b0;
        hit_dir = 1'b0;
        hit_led = 1'b0;
        if (idx <= fppio_idx_port_d_latch)
        begin
            hit_latch = 1'b1;
        end
        else if (idx <= fppio_idx_port_d_direction)
        begin
            hit_dir = 1'b1;
        end
        else if (idx == fppio_idx_port_a_led_drive_enable)
        begin
            hit_led = 1'b1;
        end
    end

    // one wait-free access phase after every setup
    always_comb
    begin
        case (state_q)
            fppio_idle:
            begin
                state_d = setup ? fppio_access : fppio_idle;
            end
            fppio_access:
            begin
                state_d = fppio_idle;
            end
            default:
            begin
                state_d = fppio_idle;
            end
        endcase
    end

    // read data taken at setup so it stands through access
    always_comb
    begin
        rdata_d = rdata_q;
        err_d = 1'b0;
        if (setup)
        begin
            rdata_d = 32'h0000_0000;
            if (hit_latch)
            begin
                rdata_d[7:0] = read_bits[idx[1:0] * 8 +: 8];
            end
            else if (hit_dir)
            begin
                rdata_d[7:0] = dir_q[idx[1:0]];
            end
            else if (hit_led)
            begin
                rdata_d[7:0] = led_q;
            end
            else
            begin
                err_d = 1'b1;
            end
        end
    end

    // register write decode
    always_comb
    begin
        for (int p = 0; p < fppio_ports; p++)
        begin
            latch_d[p] = latch_q[p];
            dir_d[p] = dir_q[p];
        end
        led_d = led_q;
        if (wr_go)
        begin
            if (hit_latch)
            begin
                latch_d[idx[1:0]] = apb_req.pwdata[7:0];
            end
            else if (hit_dir)
            begin
                dir_d[idx[1:0]] = apb_req.pwdata[7:0];
            end
            else if (hit_led)
            begin
                led_d = apb_req.pwdata[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        for (int p = 0; p < fppio_ports; p++)
        begin
            latch_q[p] <= latch_d[p];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            for (int p = 0; p < fppio_ports; p++)
            begin
                dir_q[p] <= fppio_direction_reset;
            end
            led_q <= fppio_led_reset;
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
            state_q <= fppio_idle;
        end
        else
        begin
            for (int p = 0; p < fppio_ports; p++)
            begin
                dir_q[p] <= dir_d[p];
            end
            led_q <= led_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
            state_q <= state_d;
        end
    end
endmodule : fppio_top

// ==== hdl/fppio_pkg.sv ====
package fppio_pkg;
    localparam int unsigned fppio_ports = 4;
    localparam int unsigned fppio_width = 8;
    localparam int unsigned fppio_pins = 32;
    // byte addresses are four times the printed indexes
    localparam logic [11:0] fppio_idx_port_a_latch = 12'h000;
    localparam logic [11:0] fppio_idx_port_b_latch = 12'h001;
    localparam logic [11:0] fppio_idx_port_c_latch = 12'h002;
    localparam logic [11:0] fppio_idx_port_d_latch = 12'h003;
    localparam logic [11:0] fppio_idx_port_a_direction = 12'h004;
    localparam logic [11:0] fppio_idx_port_b_direction = 12'h005;
    localparam logic [11:0] fppio_idx_port_c_direction = 12'h006;
    localparam logic [11:0] fppio_idx_port_d_direction = 12'h007;
    localparam logic [11:0] fppio_idx_port_a_led_drive_enable = 12'h00C;
    localparam logic [7:0] fppio_direction_reset = 8'h00;
    localparam logic [7:0] fppio_led_reset = 8'h00;
    // open-drain pins: port b bits 0..3, port c bits 6..7
    localparam logic [31:0] fppio_open_drain_mask = 32'h00C0_0F00;
    localparam logic [4:0] fppio_channel_limit = 5'h07;

    typedef struct packed {
        logic [11:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } fppio_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } fppio_apb_rsp_type;

    typedef struct packed {
        logic [31:0] pin_out;
        logic [31:0] pin_oe_n;
        logic [7:0] led_drive;
    } fppio_pad_type;

    typedef enum logic [0:0] {
        fppio_idle = 1'b0,
        fppio_access = 1'b1
    } fppio_state_type;
endpackage : fppio_pkg

// ==== hdl/fppio_pin_cell.sv ====
`timescale 1ns/100ps
module fppio_pin_cell
    import fppio_pkg::*;
(
    input wire logic latch_bit,
    input wire logic dir_bit,
    input wire logic open_drain,
    input wire logic periph_own,
    input wire logic periph_out,
    input wire logic periph_oe,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_n,
    output logic read_bit
);
    logic drive_val;
    logic drive_en;

    always_comb
    begin
        drive_val = periph_own ? periph_out : latch_bit;
        drive_en = periph_own ? periph_oe : dir_bit;
        if (open_drain && drive_val)
        begin
            drive_en = 1'b0;
        end
        pin_out = drive_val;
        pin_oe_n = ~drive_en;
        read_bit = dir_bit ? latch_bit : pin_in;
    end
endmodule : fppio_pin_cell

// ==== bench/fppio_checker.sv ====
`timescale 1ns/100ps
module fppio_checker
    import fppio_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire fppio_apb_req_type apb_req,
    input wire fppio_apb_rsp_type apb_rsp,
    input wire logic [31:0] pin_in,
    input wire fppio_pad_type pad,
    input wire logic [4:0] converter_channel_select,
    input wire logic [7:0] converter_input_select,
    input wire logic [31:0] periph_own,
    input wire logic [31:0] periph_out,
    input wire logic [31:0] periph_oe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // open-drain and converter pins excluded, their release rules differ
    wire [31:0] own = periph_own & ~fppio_open_drain_mask & 32'hFFFF_FF00;
    sequence s_setup;
        apb_req.psel && !apb_req.penable;
    endsequence
    sequence s_answer;
        apb_rsp.pready ##1 !apb_rsp.pready;
    endsequence
    AST_ANSWER: assert property (s_setup |=> s_answer)
        else $error("late answer");
    AST_UNMAPPED: assert property (s_setup ##0 apb_req.paddr == 12'h020
        |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("unmapped");
    AST_RESET: assert property ($fell(rst)
        |-> &(pad.pin_oe_n | periph_own) && pad.led_drive == 8'h00) else $error("reset");
    AST_OPEN: assert property (
        (fppio_open_drain_mask & ~periph_own & ~pad.pin_oe_n & pad.pin_out) == 0)
        else $error("open drain high");
    AST_CONV: assert property (converter_input_select ==
        (converter_channel_select > fppio_channel_limit ? 8'h00
        : 8'h01 << converter_channel_select[2:0])) else $error("channel");
    AST_CONV_OFF: assert property (&(pad.pin_oe_n[7:0] | ~converter_input_select))
        else $error("converter pin driven");
    AST_LED: assert property ((pad.led_drive & pad.pin_oe_n[7:0]
        & ~converter_input_select & ~periph_own[7:0]) == 0) else $error("led");
    AST_OWN: assert property ((own & (pad.pin_oe_n ^ ~periph_oe
        | (periph_oe & (pad.pin_out ^ periph_out)))) == 0) else $error("owner");
endmodule : fppio_checker

bind fppio_top fppio_checker u_chk (.sys_clk, .rst, .apb_req, .apb_rsp, .pin_in, .pad,
    .converter_channel_select, .converter_input_select, .periph_own, .periph_out, .periph_oe);

// ==== bench/fppio_pin_model.sv ====
`timescale 1ns/100ps
module fppio_pin_model
    import fppio_pkg::*;
(
    input wire fppio_pad_type pad,
    input wire logic [31:0] ext,
    output logic [31:0] pin_in
);
    // released open-drain lines sit on their pull-ups
    assign pin_in = (pad.pin_oe_n & (ext | fppio_open_drain_mask))
        | (~pad.pin_oe_n & pad.pin_out);
endmodule : fppio_pin_model

// ==== bench/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    import fppio_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] sel = 5'h1F;
    logic [31:0] own = '0, p_out = '0, p_oe = '0, pins, ext = 32'hA5C3_5A3C, rd;
    logic er;
    logic [7:0] cin;
    fppio_apb_req_type q = '0;
    fppio_apb_rsp_type rsp;
    fppio_pad_type pad;
    int fail_count = 0, n_checks = 0;
    // index, write data, expected read
    // direction a row comes before the led row
    logic [19:0] rows [9] = '{20'h4FFFF, 20'h03C3C, 20'h50F0F, 20'h10050, 20'hC5555,
        20'h60000, 20'h2FFC3, 20'h7F0F0, 20'h30F05};
    fppio_top u_dut (.sys_clk, .rst, .apb_req(q), .apb_rsp(rsp), .pin_in(pins), .pad,
        .converter_channel_select(sel), .converter_input_select(cin),
        .periph_own(own), .periph_out(p_out), .periph_oe(p_oe));
    fppio_pin_model u_pins (.pad, .ext, .pin_in(pins));
    initial forever #2 sys_clk = ~sys_clk;
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic bus(input logic [11:0] idx, input logic wr, input logic [31:0] wd,
        output logic [31:0] d, output logic e);
        int n = 0;
        @(posedge sys_clk);
        q <= '{idx << 2, 1'b1, 1'b0, wr, wd};
        @(posedge sys_clk);
        q.penable <= 1'b1;
        // answer taken at the rising edge that samples pready high
        do @(posedge sys_clk); while (rsp.pready !== 1'b1 && ++n < 20);
        d = rsp.prdata;
        e = rsp.pslverr;
        q <= '0;
        if (n >= 20)
        begin
            fail_count++;
            wrap_up();
        end
    endtask : bus
    task automatic do_reset;
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
    endtask : do_reset
    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            bus({8'h0, rows[i][19:16]}, 1'b1, {24'h0, rows[i][15:8]}, rd, er);
            bus({8'h0, rows[i][19:16]}, 1'b0, 32'h0, rd, er);
            chk(rd, {24'h0, rows[i][7:0]});
        end
        @(negedge sys_clk);
        chk(32'(pad.led_drive), 32'h55);
        bus(12'h001, 1'b1, 32'h0F, rd, er);
        @(negedge sys_clk);
        chk(32'(pad.pin_oe_n[11:8]), 32'hF);
        $display("test table done");
        for (int c = 0; c < 9; c++)
        begin
            @(posedge sys_clk);
            sel <= 5'(c);
            @(negedge sys_clk);
            chk(32'(cin), c < 8 ? 32'h1 << c : 32'h0);
        end
        @(posedge sys_clk);
        own <= 32'hFF00_0000;
        p_out <= 32'h5A00_0000;
        p_oe <= 32'hF000_0000;
        @(negedge sys_clk);
        chk(32'(pad.pin_out[31:28]), 32'h5);
        bus(12'h008, 1'b1, 32'hFF, rd, er);
        bus(12'h008, 1'b0, 32'h0, rd, er);
        chk({rd[30:0], er}, 32'h1);
        $display("test override done");
        do_reset();
        bus(12'h005, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h0);
        bus(12'h004, 1'b1, 32'hFF, rd, er);
        bus(12'h000, 1'b0, 32'h0, rd, er);
        chk(rd, 32'h3C);
        bus(12'h004, 1'b1, 32'h0F, rd, er);
        bus(12'h00C, 1'b1, 32'hFF, rd, er);
        @(negedge sys_clk);
        chk(32'(pad.led_drive), 32'h0F);
        $display("test reset done");
        wrap_up();
    end
endmodule : testbench
